// *** core/mbg_pkg.sv ***
package mbg_pkg;

	// clock and timing
	localparam int CLK_PERIOD_NS   = 50;
	localparam int PULSE_NS        = 100;
	localparam int PULSE_CYC       = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MS_NS           = 1000000;
	localparam int MS_TICK_CYC_DEF = MS_NS / CLK_PERIOD_NS;

	// buffer geometry
	localparam int BUF_DEPTH = 2048;
	localparam int PTR_W     = 11;
	localparam int CNT_W     = 12;
	localparam int ADDR_W    = 8;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_MODE       = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_OPEN_QUAL  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_OPEN_OFS   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_CLOSE_QUAL = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_CLOSE_OFS  = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_REPEAT     = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_LENGTH     = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_STOP_CNT   = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_STOP_MS    = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_READ_LIMIT = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_UNREAD     = 8'h2C;
	localparam logic [ADDR_W-1:0] OFS_FETCH_NEXT = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_FETCH_DATA = 8'h34;
	localparam logic [ADDR_W-1:0] OFS_RD_PTR     = 8'h38;
	localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h3C;

	// field positions
	localparam int CTRL_RUN_BIT    = 0;
	localparam int CTRL_CLR_BIT    = 1;
	localparam int CTRL_PROT_BIT   = 2;
	localparam int CTRL_MASTER_BIT = 3;
	localparam int MODE_SRC_LSB    = 0;
	localparam int MODE_ARM_LSB    = 4;
	localparam int STAT_SESS_BIT   = 0;
	localparam int STAT_ARMED_BIT  = 1;
	localparam int STAT_GATE_BIT   = 2;

	// reset values
	localparam logic             RST_PROTECT = 1'b1;
	localparam logic [CNT_W-1:0] RST_LIMIT   = 12'h001;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		SRC_SWEEP    = 3'h0,
		SRC_BURST    = 3'h1,
		SRC_LEVEL    = 3'h2,
		SRC_EDGE     = 3'h3,
		SRC_PERIODIC = 3'h4
	} mbg_src_t;

	typedef enum logic [1:0] {
		ARM_NOW   = 2'h0,
		ARM_PULSE = 2'h1,
		ARM_LEVEL = 2'h2
	} mbg_arm_t;

	typedef enum logic [2:0] {
		G_IDLE   = 3'h0,
		G_QOPEN  = 3'h1,
		G_WOPEN  = 3'h2,
		G_OPEN   = 3'h3,
		G_QCLOSE = 3'h4,
		G_WCLOSE = 3'h5
	} mbg_gstate_t;

	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} mbg_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} mbg_axi_rsp_t;

endpackage

// *** core/mbg_gate_session.sv ***
// Notes on behaviour
// - gate source picks one of five: sweep, burst, level, edge-timed, periodic
// - open qualify time 0..10us, used in burst, level and edge modes
// - signed open offset -10us..100ms, used in burst, level and edge modes
// - close qualify time 0..10us, used in burst and level modes only
// - close offset up to 100ms, used in burst and level modes only
// - periodic mode starts a gate every programmed interval, 100ns..10s
// - edge and periodic modes close the gate after programmed length
// - arming: at once, on external pulse, or while external level high
// - session stops after N stored entries; N of zero or less disables
// - session stops T ms after start; T of zero or less disables
// - overwrite guard stops the session instead of overwriting unread entries
// - run control starts a session; stop keeps acquired data readable
// - clear command stops session and leaves nothing to read
// - per-read limit 1..2048 bounds entries of one fetch
// - unread entry count can be queried
// - fetch-next returns up to limit unread entries, advancing read pointer
// - read pointer can be written and read back
// - sweep mode: gate from sweep window; master trigger out, slave arm out
// - burst master drives qualified gate out; slaves follow as level gate
// - level gate: entry opens on assertion, closes on deassertion
// - edge gate: opens on assertion, closes after length whatever the level
// - periodic master emits 100ns start pulse; slaves start on it
// - 2048-entry circular buffer; unguarded writes replace the oldest
// - one entry per gate interval while armed; gates ignored when disarmed
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module mbg_gate_session #(
	parameter int MS_TICK_CYC = mbg_pkg::MS_TICK_CYC_DEF
) (
	// clock and reset
	input  wire logic                  i_core_clk,
	input  wire logic                  i_rstn,
	// register bus
	input  wire mbg_pkg::mbg_axi_req_t i_axi,
	output var  mbg_pkg::mbg_axi_rsp_t o_axi,
	// internal gate sources and sweep trigger
	input  wire logic                  i_sweep_window,
	input  wire logic                  i_rf_burst,
	input  wire logic                  i_trig_out,
	// shared multi-purpose line
	input  wire logic                  i_mio,
	output logic                       o_mio,
	output logic                       o_mio_oe,
	// status
	output logic                       o_mio_level,
	output logic                       o_gate,
	output logic                       o_armed
);
	import mbg_pkg::*;

	typedef struct packed {
		mbg_axi_rsp_t      rsp;
		logic              aw_got;
		logic              w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		mbg_src_t          src;
		mbg_arm_t          arm;
		logic              master;
		logic              protect;
		logic [31:0]       open_qual;
		logic [31:0]       open_ofs;
		logic [31:0]       close_qual;
		logic [31:0]       close_ofs;
		logic [31:0]       repeat_ival;
		logic [31:0]       length;
		logic [31:0]       stop_cnt;
		logic [31:0]       stop_ms;
		logic [CNT_W-1:0]  limit;
		logic [PTR_W-1:0]  rd_ptr;
		logic [PTR_W-1:0]  wr_ptr;
		logic [CNT_W-1:0]  unread;
		logic [CNT_W-1:0]  fetch_left;
		logic              sess;
		logic              armed;
		logic [31:0]       sess_cnt;
		logic [31:0]       ms_pre;
		logic [31:0]       elapsed_ms;
		logic [2:0]        mio_sync;
		logic              mio_lvl;
		logic              mio_prev;
		mbg_gstate_t       gst;
		logic              gate_open;
		logic [31:0]       ts;
		logic [31:0]       ts_mark;
		logic [31:0]       target;
		logic [31:0]       open_ts;
		logic [31:0]       qcnt;
		logic [31:0]       lcnt;
		logic [31:0]       pcnt;
		logic [7:0]        pulse_cnt;
		logic              mio_out;
		logic              mio_oe;
	} st_t;

	st_t         s;
	st_t         next_s;
	logic [31:0] mem [BUF_DEPTH];
	logic        push;
	logic [31:0] push_data;
	logic        pop;
	logic        src_lvl;
	logic        qual_cls;
	logic        edge_cls;
	logic        timer_cls;
	logic        tick;
	logic        mio_rise;
	logic        go_open;
	logic        go_close;
	logic [31:0] rd_word;
	logic        rd_ok;
	logic        wr_ok;

	// byte-lane merge of a written word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// wrap-safe time reached test
	function automatic logic reached(input logic [31:0] now, input logic [31:0] tgt);
		logic [31:0] diff;
		diff = now - tgt;
		return ~diff[31];
	endfunction

	// read data decode
	always_comb begin
		rd_ok   = 1'b1;
		rd_word = 32'h0;
		unique case (i_axi.araddr)
			OFS_CTRL:       rd_word = {28'h0, s.master, s.protect, 1'b0, s.sess};
			OFS_MODE:       rd_word = {26'h0, s.arm, 1'b0, s.src};
			OFS_OPEN_QUAL:  rd_word = s.open_qual;
			OFS_OPEN_OFS:   rd_word = s.open_ofs;
			OFS_CLOSE_QUAL: rd_word = s.close_qual;
			OFS_CLOSE_OFS:  rd_word = s.close_ofs;
			OFS_REPEAT:     rd_word = s.repeat_ival;
			OFS_LENGTH:     rd_word = s.length;
			OFS_STOP_CNT:   rd_word = s.stop_cnt;
			OFS_STOP_MS:    rd_word = s.stop_ms;
			OFS_READ_LIMIT: rd_word = {20'h0, s.limit};
			OFS_UNREAD:     rd_word = {20'h0, s.unread};
			OFS_FETCH_NEXT: rd_word = {20'h0, s.fetch_left};
			OFS_FETCH_DATA: rd_word = (s.fetch_left != 12'h0) ? mem[s.rd_ptr] : 32'h0;
			OFS_RD_PTR:     rd_word = {21'h0, s.rd_ptr};
			OFS_STATUS:     rd_word = {29'h0, s.gate_open, s.armed, s.sess};
			default:        rd_ok = 1'b0;
		endcase
	end

	// gate source classes per mode and role
	always_comb begin
		qual_cls  = 1'b0;
		edge_cls  = 1'b0;
		timer_cls = 1'b0;
		src_lvl   = s.mio_lvl;
		unique case (s.src)
			SRC_SWEEP: src_lvl = i_sweep_window;
			SRC_BURST: begin
				qual_cls = 1'b1;
				src_lvl  = s.master ? i_rf_burst : s.mio_lvl;
			end
			SRC_LEVEL: qual_cls = 1'b1;
			SRC_EDGE: edge_cls = 1'b1;
			SRC_PERIODIC: begin
				timer_cls = s.master;
				edge_cls  = ~s.master;
			end
			default: src_lvl = 1'b0;
		endcase
	end

	// next state
	always_comb begin
		next_s    = s;
		push      = 1'b0;
		push_data = 32'h0;
		pop       = 1'b0;
		go_open   = 1'b0;
		go_close  = 1'b0;
		wr_ok     = 1'b1;
		// shared line input: three flops, change taken when last two agree
		next_s.mio_sync = {s.mio_sync[1:0], i_mio};
		if (s.mio_sync[1] == s.mio_sync[2]) begin
			next_s.mio_lvl = s.mio_sync[2];
		end
		next_s.mio_prev = s.mio_lvl;
		mio_rise        = s.mio_lvl & ~s.mio_prev;
		next_s.ts       = s.ts + 32'h1;

		// arming control
		if (s.sess) begin
			unique case (s.arm)
				ARM_PULSE: if (mio_rise) next_s.armed = 1'b1;
				ARM_LEVEL: next_s.armed = s.mio_lvl;
				default:   next_s.armed = s.armed;
			endcase
		end

		// period timer, runs only while armed
		tick = 1'b0;
		if (timer_cls && s.sess && s.armed) begin
			tick        = (s.pcnt == 32'h0);
			next_s.pcnt = (s.pcnt + 32'h1 >= s.repeat_ival) ? 32'h0 : s.pcnt + 32'h1;
		end else begin
			next_s.pcnt = 32'h0;
		end
		if (tick) begin
			next_s.pulse_cnt = 8'(PULSE_CYC);
		end else if (s.pulse_cnt != 8'h0) begin
			next_s.pulse_cnt = s.pulse_cnt - 8'h1;
		end

		// gate sequence
		unique case (s.gst)
			G_IDLE: begin
				if (s.sess && s.armed) begin
					if (timer_cls) begin
						go_open = tick;
					end else if (qual_cls ? src_lvl : (edge_cls ? mio_rise : 1'b0)) begin
						next_s.qcnt    = 32'h0;
						next_s.ts_mark = s.ts;
						next_s.gst     = G_QOPEN;
					end else if (s.src == SRC_SWEEP) begin
						go_open = i_sweep_window;
					end
				end
			end
			G_QOPEN: begin
				if (!src_lvl) begin
					next_s.gst = G_IDLE;
				end else if (s.qcnt >= s.open_qual) begin
					next_s.target = s.ts_mark + s.open_ofs;
					next_s.gst    = G_WOPEN;
				end else begin
					next_s.qcnt = s.qcnt + 32'h1;
				end
			end
			G_WOPEN: go_open = reached(s.ts, s.target);
			G_OPEN: begin
				next_s.lcnt = s.lcnt + 32'h1;
				if (edge_cls || timer_cls) begin
					go_close = (s.lcnt + 32'h1 >= s.length);
				end else if (qual_cls) begin
					if (!src_lvl) begin
						next_s.qcnt    = 32'h0;
						next_s.ts_mark = s.ts;
						next_s.gst     = G_QCLOSE;
					end
				end else begin
					go_close = ~i_sweep_window;
				end
			end
			G_QCLOSE: begin
				if (src_lvl) begin
					next_s.gst = G_OPEN; // brief dip, stay open
				end else if (s.qcnt >= s.close_qual) begin
					next_s.target = s.ts_mark + s.close_ofs;
					next_s.gst    = G_WCLOSE;
				end else begin
					next_s.qcnt = s.qcnt + 32'h1;
				end
			end
			G_WCLOSE: go_close = reached(s.ts, s.target);
			default: next_s.gst = G_IDLE;
		endcase
		if (go_open) begin
			next_s.gate_open = 1'b1;
			next_s.open_ts   = s.ts;
			next_s.lcnt      = 32'h0;
			next_s.gst       = G_OPEN;
		end
		if (go_close) begin
			push             = 1'b1;
			push_data        = s.ts - s.open_ts;
			next_s.gate_open = 1'b0;
			next_s.gst       = G_IDLE;
		end
		// disarm aborts an interval without storing it
		if (!s.sess || !s.armed) begin
			push             = 1'b0;
			next_s.gate_open = 1'b0;
			next_s.gst       = G_IDLE;
		end

		// write channel
		if (i_axi.awvalid && s.rsp.awready) begin
			next_s.aw_got = 1'b1;
			next_s.awaddr = i_axi.awaddr;
		end
		if (i_axi.wvalid && s.rsp.wready) begin
			next_s.w_got = 1'b1;
			next_s.wdata = i_axi.wdata;
			next_s.wstrb = i_axi.wstrb;
		end
		if (s.rsp.bvalid && i_axi.bready) begin
			next_s.rsp.bvalid = 1'b0;
		end

		// read channel, fetch data read pops one entry while the fetch count is nonzero
		if (s.rsp.rvalid && i_axi.rready) begin
			next_s.rsp.rvalid = 1'b0;
		end
		if (i_axi.arvalid && s.rsp.arready) begin
			next_s.rsp.rvalid = 1'b1;
			next_s.rsp.rdata  = rd_word;
			next_s.rsp.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
			if (i_axi.araddr == OFS_FETCH_DATA && s.fetch_left != 12'h0) begin
				pop               = 1'b1;
				next_s.fetch_left = s.fetch_left - 12'h1;
			end
		end

		// buffer bookkeeping
		if (push) begin
			next_s.wr_ptr   = s.wr_ptr + 11'h1;
			next_s.sess_cnt = s.sess_cnt + 32'h1;
		end
		if (pop) begin
			next_s.rd_ptr = s.rd_ptr + 11'h1;
		end
		if (push && !pop && s.unread == 12'(BUF_DEPTH)) begin
			next_s.rd_ptr = s.rd_ptr + 11'h1;
		end else begin
			next_s.unread = s.unread + {11'h0, push} - {11'h0, pop};
		end

		// elapsed session time in ms
		if (s.sess) begin
			if (s.ms_pre + 32'h1 >= 32'(MS_TICK_CYC)) begin
				next_s.ms_pre     = 32'h0;
				next_s.elapsed_ms = s.elapsed_ms + 32'h1;
			end else begin
				next_s.ms_pre = s.ms_pre + 32'h1;
			end
		end

		// auto-stop, first condition met ends the session
		if (s.sess) begin
			if (($signed(s.stop_cnt) > 0 && next_s.sess_cnt >= s.stop_cnt)
				|| ($signed(s.stop_ms) > 0 && next_s.elapsed_ms >= s.stop_ms)
				|| (s.protect && next_s.unread == 12'(BUF_DEPTH))) begin
				next_s.sess  = 1'b0;
				next_s.armed = 1'b0;
			end
		end

		// register write, applied once address and data are both held
		if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
			next_s.aw_got     = 1'b0;
			next_s.w_got      = 1'b0;
			next_s.rsp.bvalid = 1'b1;
			unique case (s.awaddr)
				OFS_CTRL: begin
					if (s.wstrb[0]) begin
						next_s.protect = s.wdata[CTRL_PROT_BIT];
						next_s.master  = s.wdata[CTRL_MASTER_BIT];
						if (s.wdata[CTRL_CLR_BIT] || s.wdata[CTRL_RUN_BIT]) begin
							next_s.rd_ptr     = '0;
							next_s.wr_ptr     = '0;
							next_s.unread     = '0;
							next_s.fetch_left = '0;
							next_s.sess_cnt   = 32'h0;
						end
						if (s.wdata[CTRL_CLR_BIT]) begin
							next_s.sess  = 1'b0;
							next_s.armed = 1'b0;
						end else if (s.wdata[CTRL_RUN_BIT]) begin
							next_s.sess       = 1'b1;
							next_s.armed      = (s.arm == ARM_NOW)
								|| (s.arm == ARM_LEVEL && s.mio_lvl);
							next_s.elapsed_ms = 32'h0;
							next_s.ms_pre     = 32'h0;
						end else begin
							next_s.sess  = 1'b0;
							next_s.armed = 1'b0;
						end
					end
				end
				OFS_MODE: begin
					if (s.wstrb[0]) begin
						next_s.src = mbg_src_t'(s.wdata[MODE_SRC_LSB +: 3]);
						next_s.arm = mbg_arm_t'(s.wdata[MODE_ARM_LSB +: 2]);
					end
				end
				OFS_OPEN_QUAL:  next_s.open_qual = merge(s.open_qual, s.wdata, s.wstrb);
				OFS_OPEN_OFS:   next_s.open_ofs = merge(s.open_ofs, s.wdata, s.wstrb);
				OFS_CLOSE_QUAL: next_s.close_qual = merge(s.close_qual, s.wdata, s.wstrb);
				OFS_CLOSE_OFS:  next_s.close_ofs = merge(s.close_ofs, s.wdata, s.wstrb);
				OFS_REPEAT:     next_s.repeat_ival = merge(s.repeat_ival, s.wdata, s.wstrb);
				OFS_LENGTH:     next_s.length = merge(s.length, s.wdata, s.wstrb);
				OFS_STOP_CNT:   next_s.stop_cnt = merge(s.stop_cnt, s.wdata, s.wstrb);
				OFS_STOP_MS:    next_s.stop_ms = merge(s.stop_ms, s.wdata, s.wstrb);
				OFS_READ_LIMIT: begin
					next_s.limit = (s.wdata[CNT_W-1:0] == 12'h0) ? 12'h001
						: (s.wdata[CNT_W-1:0] > 12'(BUF_DEPTH)) ? 12'(BUF_DEPTH)
						: s.wdata[CNT_W-1:0];
				end
				OFS_FETCH_NEXT: begin
					next_s.fetch_left = (s.limit < next_s.unread) ? s.limit
						: next_s.unread;
				end
				OFS_RD_PTR: begin
					next_s.rd_ptr     = s.wdata[PTR_W-1:0];
					next_s.unread     = {1'b0, next_s.wr_ptr - s.wdata[PTR_W-1:0]};
					next_s.fetch_left = '0;
				end
				OFS_UNREAD, OFS_FETCH_DATA, OFS_STATUS: wr_ok = 1'b1;
				default: wr_ok = 1'b0;
			endcase
			next_s.rsp.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		// a session that disarms in this cycle opens no gate
		if (!next_s.armed) begin
			next_s.gate_open = 1'b0;
			next_s.gst       = G_IDLE;
		end
		next_s.rsp.awready = ~next_s.aw_got & ~next_s.rsp.bvalid;
		next_s.rsp.wready  = ~next_s.w_got & ~next_s.rsp.bvalid;
		next_s.rsp.arready = ~next_s.rsp.rvalid;

		// shared line drive per mode and role; master level and edge modes and non-sweep slaves leave it released
		next_s.mio_oe  = 1'b0;
		next_s.mio_out = 1'b0;
		if (s.master) begin
			unique case (s.src)
				SRC_SWEEP: begin
					next_s.mio_oe  = 1'b1;
					next_s.mio_out = i_trig_out;
				end
				SRC_BURST: begin
					next_s.mio_oe  = 1'b1;
					next_s.mio_out = s.gate_open;
				end
				SRC_PERIODIC: begin
					next_s.mio_oe  = 1'b1;
					next_s.mio_out = (s.pulse_cnt != 8'h0);
				end
				default: next_s.mio_oe = 1'b0;
			endcase
		end else if (s.src == SRC_SWEEP) begin
			next_s.mio_oe  = 1'b1;
			next_s.mio_out = s.armed;
		end
	end

	// state register
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s         <= '0;
			s.protect <= RST_PROTECT;
			s.limit   <= RST_LIMIT;
		end else begin
			s <= next_s;
		end
	end

	// entry memory, one word per gate interval
	always_ff @(posedge i_core_clk) begin
		if (push) begin
			mem[s.wr_ptr] <= push_data;
		end
	end

	// outputs straight from state
	assign o_axi       = s.rsp;
	assign o_mio       = s.mio_out;
	assign o_mio_oe    = s.mio_oe;
	assign o_mio_level = s.mio_lvl;
	assign o_gate      = s.gate_open;
	assign o_armed     = s.armed;

endmodule

`default_nettype wire

// *** testbench/mbg_gate_session_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module mbg_gate_session_chk (
	input wire logic                  i_core_clk,
	input wire logic                  i_rstn,
	input wire mbg_pkg::mbg_axi_req_t i_axi,
	input wire mbg_pkg::mbg_axi_rsp_t o_axi,
	input wire logic                  i_mio,
	input wire logic                  o_mio,
	input wire logic                  o_mio_oe,
	input wire logic                  o_mio_level,
	input wire logic                  o_gate,
	input wire logic                  o_armed
);
	import mbg_pkg::*;
	logic [7:0]  aq;
	logic [31:0] wq;
	logic        mst;
	logic [2:0]  src;
	// shadow of role and gate source, taken when the write answer comes
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			aq  <= '0;
			wq  <= '0;
			mst <= 1'b0;
			src <= 3'h0;
		end else begin
			if (i_axi.awvalid && o_axi.awready)
				aq <= i_axi.awaddr;
			if (i_axi.wvalid && o_axi.wready)
				wq <= i_axi.wdata;
			if ($rose(o_axi.bvalid) && aq == OFS_CTRL)
				mst <= wq[CTRL_MASTER_BIT];
			if ($rose(o_axi.bvalid) && aq == OFS_MODE)
				src <= wq[2:0];
		end
	end
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);
	bvalid_hold_a: assert property (o_axi.bvalid && !i_axi.bready
		|=> o_axi.bvalid && $stable(o_axi.bresp)) else $error("write answer dropped");
	rvalid_hold_a: assert property (o_axi.rvalid && !i_axi.rready
		|=> o_axi.rvalid && $stable(o_axi.rdata)) else $error("read answer dropped");
	read_answer_a: assert property (i_axi.arvalid && o_axi.arready
		|=> o_axi.rvalid && !o_axi.arready) else $error("read answer late");
	write_answer_a: assert property (i_axi.awvalid && o_axi.awready && i_axi.wvalid
		&& o_axi.wready |-> ##2 o_axi.bvalid) else $error("write answer late");
	gate_armed_a: assert property ($rose(o_gate) |-> o_armed)
		else $error("gate opened while disarmed");
	slave_quiet_a: assert property (!mst && src != SRC_SWEEP |-> !o_mio_oe)
		else $error("slave drives shared line");
	sweep_armout_a: assert property ($rose(o_armed) && !mst && src == SRC_SWEEP
		|-> ##[0:1] (o_mio && o_mio_oe)) else $error("arm status not sent");
	start_pulse_a: assert property (mst && src == SRC_PERIODIC && $rose(o_mio)
		|-> ##1 o_mio ##1 !o_mio) else $error("start pulse width wrong");
	level_filter_a: assert property ($stable(i_mio) [*6]
		|-> o_mio_level == i_mio) else $error("line level not followed");
	cover property (mst && src == SRC_PERIODIC && $rose(o_mio));
	cover property ($fell(o_gate));
	cover property (o_axi.rvalid && o_axi.rresp == RESP_SLVERR);
endmodule
bind mbg_gate_session mbg_gate_session_chk chk_u (
	.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_axi(i_axi), .o_axi(o_axi),
	.i_mio(i_mio), .o_mio(o_mio), .o_mio_oe(o_mio_oe),
	.o_mio_level(o_mio_level), .o_gate(o_gate), .o_armed(o_armed)
);
`default_nettype wire

// *** testbench/mbg_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module mbg_peer (
	input  wire logic        i_core_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_go,
	input  wire logic [15:0] i_len,
	output logic             o_drv,
	output logic             o_oe
);
	logic [15:0] cnt;
	// outside gate source: high for i_len cycles, then released to the pull-down
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn)
			cnt <= '0;
		else if (i_go)
			cnt <= i_len;
		else if (cnt != 16'h0)
			cnt <= cnt - 16'h1;
	end
	assign o_oe  = (cnt != 16'h0);
	assign o_drv = o_oe;
endmodule
`default_nettype wire

// *** testbench/mbg_gate_session_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module mbg_gate_session_tb;
	import mbg_pkg::*;
	logic         clk = 1'b0;
	logic         rstn = 1'b0;
	mbg_axi_req_t axi = '0;
	mbg_axi_rsp_t rsp;
	logic         go = 1'b0;
	logic         trig = 1'b0;
	logic [15:0]  glen = 16'h0;
	logic         mio, mio_oe, pdrv, poe, mio_w;
	logic [31:0]  d, p;
	logic [1:0]   r;
	logic         gate, armed, mlvl;
	int           err_total = 0;
	int           n_tests = 0;
	int           cyc = 0;
	int           l;
	// pull-down line: released means low
	assign mio_w = mio_oe ? mio : (poe ? pdrv : 1'b0);
	mbg_gate_session #(.MS_TICK_CYC(20)) dut_u (
		.i_core_clk(clk), .i_rstn(rstn), .i_axi(axi), .o_axi(rsp),
		.i_sweep_window(poe), .i_rf_burst(poe), .i_trig_out(trig),
		.i_mio(mio_w), .o_mio(mio), .o_mio_oe(mio_oe),
		.o_mio_level(mlvl), .o_gate(gate), .o_armed(armed)
	);
	mbg_peer peer_u (
		.i_core_clk(clk), .i_rstn(rstn), .i_go(go), .i_len(glen),
		.o_drv(pdrv), .o_oe(poe)
	);
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic results;
		$display("errors=%0d compares=%0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// watchdog and random sweep trigger
	always @(posedge clk) begin
		cyc <= cyc + 1;
		trig <= 1'($urandom);
		if (cyc == 40000) begin
			err_total++;
			results();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		axi <= '{1'b1, a, 1'b1, v, 4'hF, 1'b1, 1'b0, 8'h00, 1'b0};
		do begin
			@(posedge clk);
			if (rsp.awready)
				axi.awvalid <= 1'b0;
			if (rsp.wready)
				axi.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		axi.bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		axi.arvalid <= 1'b1;
		axi.araddr <= a;
		axi.rready <= 1'b1;
		do begin
			@(posedge clk);
			if (rsp.arready)
				axi.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		axi.rready <= 1'b0;
		d = rsp.rdata;
		r = rsp.rresp;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] x);
		rd(a);
		chk(d, x);
	endtask
	// outside gate pulse of n cycles; lv asks for a look at the filtered line level
	task automatic pulse(input int n, input logic lv);
		@(posedge clk);
		go <= 1'b1;
		glen <= 16'(n);
		@(posedge clk);
		go <= 1'b0;
		repeat (6) @(posedge clk);
		if (lv)
			chk({31'h0, mlvl}, 32'h1);
		repeat (n + 34) @(posedge clk);
	endtask
	// expected stored length of a level gate with open and close offsets
	function automatic logic [31:0] gate_len(input int n, input int t_open, input int t_close);
		return 32'(n + t_close - t_open);
	endfunction
	// main sequence
	initial begin
		void'($urandom(32'hEA4D1140));
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		rc(OFS_CTRL, 32'h4);
		rc(OFS_READ_LIMIT, 32'h1);
		rd(8'h40);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(OFS_LENGTH, 32'hC);
		wr(OFS_STOP_CNT, 32'h2);
		for (int m = 0; m < 4; m++) begin
			wr(OFS_CTRL, 32'h6);
			rc(OFS_UNREAD, 32'h0);
			wr(OFS_MODE, m);
			wr(OFS_CTRL, (m == 1) ? 32'hD : 32'h5);
			l = $urandom_range(20, 4);
			repeat (3) pulse(l, m > 1);
			rc(OFS_UNREAD, 32'h2);
			rd(OFS_RD_PTR);
			p = d;
			wr(OFS_FETCH_NEXT, 32'h0);
			rc(OFS_FETCH_NEXT, 32'h1);
			rc(OFS_FETCH_DATA, (m == 3) ? 32'hC : gate_len(l, 0, 0));
			rc(OFS_FETCH_DATA, 32'h0);
			rc(OFS_RD_PTR, p + 32'h1);
			rc(OFS_UNREAD, 32'h1);
		end
		wr(OFS_RD_PTR, p);
		rc(OFS_UNREAD, 32'h2);
		wr(OFS_READ_LIMIT, 32'hBB8);
		rc(OFS_READ_LIMIT, 32'h800);
		for (int a = 1; a < 3; a++) begin
			wr(OFS_CTRL, 32'h6);
			wr(OFS_MODE, a * 16 + 2);
			wr(OFS_CTRL, 32'h5);
			rc(OFS_STATUS, 32'h1);
			pulse(5, 1'b1);
			rc(OFS_STATUS, (a == 1) ? 32'h3 : 32'h1);
			chk({30'h0, armed, gate}, (a == 1) ? 32'h2 : 32'h0);
		end
		wr(OFS_CTRL, 32'h4);
		rc(OFS_STATUS, 32'h0);
		// qualified level gate with open and close offsets
		wr(OFS_CTRL, 32'h6);
		wr(OFS_MODE, 32'h2);
		wr(OFS_OPEN_QUAL, 32'h2);
		wr(OFS_OPEN_OFS, 32'h6);
		wr(OFS_CLOSE_QUAL, 32'h1);
		wr(OFS_CLOSE_OFS, 32'h4);
		wr(OFS_CTRL, 32'h5);
		l = $urandom_range(30, 8);
		pulse(l, 1'b1);
		wr(OFS_FETCH_NEXT, 32'h0);
		rc(OFS_FETCH_DATA, gate_len(l, 6, 4));
		wr(OFS_CTRL, 32'h6);
		wr(OFS_MODE, 32'h4);
		wr(OFS_REPEAT, 32'hA);
		wr(OFS_LENGTH, 32'h4);
		wr(OFS_STOP_CNT, 32'h0);
		wr(OFS_STOP_MS, 32'h2);
		wr(OFS_CTRL, 32'hD);
		repeat (150) @(posedge clk);
		rc(OFS_STATUS, 32'h0);
		rc(OFS_UNREAD, 32'h4);
		wr(OFS_FETCH_NEXT, 32'h0);
		rc(OFS_FETCH_DATA, 32'h4);
		for (int g = 0; g < 2; g++) begin
			wr(OFS_CTRL, 32'h6);
			wr(OFS_STOP_MS, 32'h0);
			wr(OFS_REPEAT, 32'h4);
			wr(OFS_LENGTH, 32'h2);
			wr(OFS_CTRL, g ? 32'h9 : 32'hD);
			repeat (8400) @(posedge clk);
			rd(OFS_STATUS);
			chk({31'h0, d[0]}, 32'(g));
			rc(OFS_UNREAD, 32'h800);
		end
		results();
	end
endmodule
`default_nettype wire
